// ==== sir_core_model.sv ====
/*
 Processor core stand-in: samples the two active-low interrupt lines.
 Assumes the lines are registered outputs of the router on i_clk.
*/
`timescale 1ns/1ps
module sir_core_model (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // Lines from the router, active low.
   input  wire logic i_normal_n,
   input  wire logic i_fast_n,
   // Requests as the core sees them.
   output logic      o_normal_req,
   output logic      o_fast_req
);
   ////////////////////////////////////////////////////////////
   // The core samples its lines once per cycle, one cycle late.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_normal_req <= 1'b0;
         o_fast_req   <= 1'b0;
      end else begin
         o_normal_req <= !i_normal_n;
         o_fast_req   <= !i_fast_n;
      end
   end
endmodule : sir_core_model

// ==== sir_params.svh ====
/*
 Constants of the system interrupt router: address windows, source numbers,
 clock-lock masks, register offsets and field positions.
 Assumes it is included by its bare name from every design file that needs it.
*/
// Notes on behaviour
// - System registers decode inside top address window.
// - User peripherals decode in 16 KB slots.
// - Source 0 is the fast pin only.
// - Source 1 ORs seven system units.
// - Sources 2 to 28 fixed; 15,16 reserved.
// - Sources 29-31 are external pins, unclocked.
// - Clock set/clear ignore locked identifier bits.
// - System clocks always on; ids 0 and 20 interrupt-only.
// - Eight priority levels with nested preemption.
// - Per-source mask, edge or level, polarity.
// - Vector per source; vector read returns current.
// - Fast forcing moves sources to fast line.
// - Protect mode suppresses the vector-read entry; the spurious flag is still set.
`ifndef SIR_PARAMS_SVH
`define SIR_PARAMS_SVH

// Address windows.
`define SIR_SYS_LO          32'hffffe800
`define SIR_SYS_HI          32'hffffffff
`define SIR_USR_LO          32'hfffa0000
`define SIR_USR_HI          32'hfffcffff
`define SIR_USR_SLOT_SHIFT  14

// Source numbering and locked bits.
`define SIR_NUM_SRC         32
`define SIR_NUM_SYS         7
`define SIR_RESERVED_MASK   32'h00018000
`define SIR_CLK_LOCK_MASK   32'he0100003
`define SIR_CLK_LOCK_VAL    32'h00000002

// Source mode fields and reset value.
`define SIR_MODE_W          7
`define SIR_MODE_POL_BIT    5
`define SIR_MODE_EDGE_BIT   6
`define SIR_MODE_RST        7'h20

// Register byte offsets (address bits 8:0).
`define SIR_OFS_MODE        9'h000
`define SIR_OFS_VEC         9'h080
`define SIR_OFS_IVR         9'h100
`define SIR_OFS_CUR         9'h104
`define SIR_OFS_EN_SET      9'h108
`define SIR_OFS_EN_CLR      9'h10c
`define SIR_OFS_EN          9'h110
`define SIR_OFS_PEND        9'h114
`define SIR_OFS_FFORCE      9'h118
`define SIR_OFS_EOC         9'h11c
`define SIR_OFS_DBG         9'h120
`define SIR_OFS_CLK_SET     9'h124
`define SIR_OFS_CLK_CLR     9'h128
`define SIR_OFS_CLK         9'h12c
`define SIR_OFS_STS         9'h130
`define SIR_OFS_MSK         9'h134
`define SIR_OFS_PROBE       9'h138
`define SIR_OFS_DEC         9'h13c
`define SIR_OFS_RAW         9'h140
`define SIR_OFS_SPUR        9'h144
`define SIR_OFS_PEND_CLR    9'h148

// Status event bits.
`define SIR_EV_NORM         0
`define SIR_EV_FAST         1
`define SIR_EV_OVF          2
`define SIR_EV_SPUR         3

`endif

// ==== sir_pkg.sv ====
/*
 Types shared by the system interrupt router.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sir_pkg;
   typedef logic [4:0]  sir_src_id_t;
   typedef logic [2:0]  sir_prio_t;
   typedef logic [31:0] sir_word_t;
endpackage : sir_pkg

// ==== sir_src_cond.sv ====
/*
 One interrupt source conditioner: edge or level detection with polarity.
 Assumes the raw input is synchronous to i_clk.
*/
`timescale 1ns/1ps
module sir_src_cond
   import sir_pkg::*;
(
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   // Source and control.
   input  wire logic       i_raw,
   input  wire logic       i_edge_mode,
   input  wire logic       i_pol_high,
   input  wire logic       i_clr,
   // Result.
   output logic            o_pend
);
   logic raw_q;
   logic edge_pend_q;
   logic active;
   logic edge_hit;

   // Polarity folds both edge and level variants onto one active sense.
   assign active   = i_pol_high ? i_raw : ~i_raw;
   assign edge_hit = i_pol_high ? (i_raw & ~raw_q) : (~i_raw & raw_q);
   assign o_pend   = i_edge_mode ? edge_pend_q : active;

   // A new edge in the clearing cycle wins, so no event is lost. The input is
   // tracked through reset, so a pin already active at release is no edge, and
   // edges are kept only in edge mode, so a later mode switch finds no stale event.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         raw_q       <= i_raw;
         edge_pend_q <= 1'b0;
      end else begin
         raw_q       <= i_raw;
         edge_pend_q <= i_edge_mode & (edge_hit | (edge_pend_q & ~i_clr));
      end
   end
endmodule : sir_src_cond

// ==== sir_top.sv ====
/*
 System interrupt router: source assembly, vectored priority controller,
 clock-lock filter for the peripheral clock enables and address decode probe.
 Assumes an Avalon-MM master with waitrequest on i_clk and synchronous inputs.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sir_params.svh"
module sir_top
   import sir_pkg::*;
#(
   parameter int STACK_DEPTH = 8
)(
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // Avalon-MM slave.
   input  wire logic [8:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Interrupt sources.
   input  wire logic        i_fast_request_pin,
   input  wire logic [6:0]  i_system_block_irq,
   input  wire logic [26:0] i_periph_irq,
   input  wire logic [2:0]  i_ext_request_pins,
   // Core lines, clock enables and own interrupt.
   output logic             o_core_normal_irq_line_n,
   output logic             o_core_fast_irq_line_n,
   output logic [31:0]      o_periph_clk_en,
   output logic             o_irq
);
   localparam logic [31:0] RES_MASK  = `SIR_RESERVED_MASK;
   localparam logic [31:0] LOCK_MASK = `SIR_CLK_LOCK_MASK;
   localparam logic [31:0] LOCK_VAL  = `SIR_CLK_LOCK_VAL;
   localparam logic [3:0]  DEPTH     = 4'(STACK_DEPTH);

   //////////////////////////////////////////////////////////////////////////
   // Functions.

   // Byte-lane merge of a write into an old value.
   function automatic sir_word_t sir_be_merge(input sir_word_t old_v,
                                              input sir_word_t new_v,
                                              input logic [3:0] be);
      sir_word_t r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : sir_be_merge

   // Address probe: bit0 system window, bit1 user window, bits 7:4 slot.
   function automatic sir_word_t sir_addr_decode(input sir_word_t a);
      sir_word_t r;
      sir_word_t off;
      r   = 32'h0000_0000;
      off = a - `SIR_USR_LO;
      r[0] = (a >= `SIR_SYS_LO) && (a <= `SIR_SYS_HI);
      r[1] = (a >= `SIR_USR_LO) && (a <= `SIR_USR_HI);
      if (r[1]) begin
         r[7:4] = 4'(off >> `SIR_USR_SLOT_SHIFT);
      end
      return r;
   endfunction : sir_addr_decode

   // Highest-priority candidate; the lowest number wins a tie.
   function automatic logic [8:0] sir_pick(input logic [31:0] cand,
                                           input logic [95:0] pr);
      logic       f;
      sir_src_id_t id;
      sir_prio_t   p;
      f  = 1'b0;
      id = 5'h00;
      p  = 3'h0;
      for (int i = 1; i < 32; i++) begin
         if (cand[i] && (!f || pr[i*3 +: 3] > p)) begin
            f  = 1'b1;
            id = 5'(i);
            p  = pr[i*3 +: 3];
         end
      end
      return {f, id, p};
   endfunction : sir_pick

   //////////////////////////////////////////////////////////////////////////
   // State.

   logic [`SIR_MODE_W-1:0] mode_q [`SIR_NUM_SRC];
   sir_word_t   vec_q [`SIR_NUM_SRC];
   sir_src_id_t stk_id_q [STACK_DEPTH];
   sir_prio_t   stk_pr_q [STACK_DEPTH];
   logic [3:0]  sp_q;
   sir_word_t   en_q, ff_q, clk_q, sts_q, msk_q, probe_q, spur_q;
   logic        protect_q, wait_q, norm_n_q, fast_n_q, irq_q;
   logic        norm_req_q, fast_req_q;
   logic        ivr_ok_q;
   sir_src_id_t ivr_id_q;
   sir_prio_t   ivr_pr_q;
   sir_word_t   rdata_q;

   //////////////////////////////////////////////////////////////////////////
   // Source assembly.

   sir_word_t src_raw, pend, clr_vec, cand_norm, cand_fast;
   logic [95:0] prio_flat;

   // Source 0 fast pin, 1 wired-OR level, 2..28 fixed, 29..31 external pins.
   assign src_raw = {i_ext_request_pins,
                     i_periph_irq & ~RES_MASK[28:2],
                     |i_system_block_irq,
                     i_fast_request_pin};

   for (genvar g = 0; g < `SIR_NUM_SRC; g++) begin : g_src
      sir_src_cond u_cond (
         .i_clk       (i_clk),
         .i_sys_rst   (i_sys_rst),
         .i_raw       (src_raw[g]),
         .i_edge_mode (mode_q[g][`SIR_MODE_EDGE_BIT]),
         .i_pol_high  (mode_q[g][`SIR_MODE_POL_BIT]),
         .i_clr       (clr_vec[g]),
         .o_pend      (pend[g])
      );
      assign prio_flat[g*3 +: 3] = mode_q[g][2:0];
   end

   //////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic        req, cap, acc, acc_wr, acc_rd;
   logic [8:0]  adr;
   logic [4:0]  aidx;
   logic        sel_mode, sel_vec;
   sir_word_t   wmask, rd_mux, probe_dec;

   assign req      = i_avs_read | i_avs_write;
   assign cap      = req & wait_q;
   assign acc      = req & ~wait_q;
   assign acc_wr   = acc & i_avs_write;
   assign acc_rd   = acc & i_avs_read;
   assign adr      = {i_avs_address[8:2], 2'b00};
   assign aidx     = i_avs_address[6:2];
   assign sel_mode = (adr[8:7] == 2'b00);
   assign sel_vec  = (adr[8:7] == 2'b01);
   assign wmask    = sir_be_merge(32'h0000_0000, i_avs_writedata, i_avs_byteenable);
   // Decode of the probe register, shared by the read path and the checks.
   assign probe_dec = sir_addr_decode(probe_q);

   //////////////////////////////////////////////////////////////////////////
   // Priority controller.

   logic [8:0]  pick;
   logic        best_ok, norm_req, fast_req, entry, eoc, ivr_wr_entry;
   sir_src_id_t best_id;
   sir_prio_t   best_pr, top_pr;
   sir_src_id_t cur_id;

   // Fast-forced sources never compete for the normal line.
   // Reserved sources are dropped after conditioning too, since an inverted
   // level mode would otherwise make their grounded inputs pend.
   assign cand_norm = pend & en_q & ~ff_q & ~RES_MASK & 32'hffff_fffe;
   assign cand_fast = pend & en_q & ~RES_MASK & (ff_q | 32'h0000_0001);
   assign pick      = sir_pick(cand_norm, prio_flat);
   assign best_ok   = pick[8];
   assign best_id   = pick[7:3];
   assign best_pr   = pick[2:0];
   assign top_pr    = (sp_q == 4'h0) ? 3'h0 : stk_pr_q[3'(sp_q - 4'h1)];
   assign cur_id    = (sp_q == 4'h0) ? 5'h00 : stk_id_q[3'(sp_q - 4'h1)];
   assign norm_req  = best_ok && ((sp_q == 4'h0) || (best_pr > top_pr));
   assign fast_req  = |cand_fast;
   // In protect mode a read of the vector does no entry but can still flag spurious; a write does the entry.
   assign ivr_wr_entry = acc_wr && (adr == `SIR_OFS_IVR) && protect_q;
   assign entry     = ((acc_rd && !protect_q) || ivr_wr_entry) && (adr == `SIR_OFS_IVR)
                      && ivr_ok_q;
   assign eoc       = acc_wr && (adr == `SIR_OFS_EOC) && (sp_q != 4'h0);
   assign clr_vec   = ((acc_wr && adr == `SIR_OFS_PEND_CLR) ? wmask : 32'h0000_0000)
                    | (entry ? (32'h0000_0001 << ivr_id_q) : 32'h0000_0000);

   // Nesting stack of serviced sources.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sp_q <= 4'h0;
      end else if (entry && sp_q != DEPTH) begin
         stk_id_q[3'(sp_q)] <= ivr_id_q;
         stk_pr_q[3'(sp_q)] <= ivr_pr_q;
         sp_q               <= sp_q + 4'h1;
      end else if (eoc) begin
         sp_q <= sp_q - 4'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers.

   sir_word_t clk_mask_wr, sts_set;

   // Locked identifiers are filtered out of every clock set or clear.
   assign clk_mask_wr = wmask & ~LOCK_MASK;
   assign sts_set = {28'h0000000,
                     (acc_rd && adr == `SIR_OFS_IVR && !ivr_ok_q),
                     (entry && sp_q == DEPTH),
                     (fast_req && !fast_req_q),
                     (norm_req && !norm_req_q)};

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < `SIR_NUM_SRC; i++) begin
            mode_q[i] <= `SIR_MODE_RST;
            vec_q[i]  <= 32'h0000_0000;
         end
         en_q      <= 32'h0000_0000;
         ff_q      <= 32'h0000_0000;
         clk_q     <= LOCK_VAL;
         sts_q     <= 32'h0000_0000;
         msk_q     <= 32'h0000_0000;
         probe_q   <= 32'h0000_0000;
         spur_q    <= 32'h0000_0000;
         protect_q <= 1'b0;
      end else begin
         // Hardware set wins over a same-cycle write-one clear.
         sts_q <= (sts_q & ~((acc_wr && adr == `SIR_OFS_STS) ? wmask : 32'h0)) | sts_set;
         if (acc_wr) begin
            if (sel_mode) begin
               mode_q[aidx] <= 7'(sir_be_merge(32'(mode_q[aidx]), i_avs_writedata,
                                               i_avs_byteenable));
            end
            if (sel_vec) begin
               vec_q[aidx] <= sir_be_merge(vec_q[aidx], i_avs_writedata,
                                           i_avs_byteenable);
            end
            case (adr)
               `SIR_OFS_EN_SET:  en_q      <= en_q | wmask;
               `SIR_OFS_EN_CLR:  en_q      <= en_q & ~wmask;
               `SIR_OFS_FFORCE:  ff_q      <= sir_be_merge(ff_q, i_avs_writedata,
                                                           i_avs_byteenable) & 32'hffff_fffe;
               `SIR_OFS_DBG:     protect_q <= wmask[0] | (protect_q & ~i_avs_byteenable[0]);
               `SIR_OFS_CLK_SET: clk_q     <= clk_q | clk_mask_wr;
               `SIR_OFS_CLK_CLR: clk_q     <= clk_q & ~clk_mask_wr;
               `SIR_OFS_MSK:     msk_q     <= sir_be_merge(msk_q, i_avs_writedata,
                                                           i_avs_byteenable);
               `SIR_OFS_PROBE:   probe_q   <= sir_be_merge(probe_q, i_avs_writedata,
                                                           i_avs_byteenable);
               `SIR_OFS_SPUR:    spur_q    <= sir_be_merge(spur_q, i_avs_writedata,
                                                           i_avs_byteenable);
               default:          ;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read path. Data is captured in the first request cycle and the winner
   // is latched with it, so the entry pushes exactly the vector handed out.

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_mode) begin
         rd_mux = 32'(mode_q[aidx]);
      end else if (sel_vec) begin
         rd_mux = vec_q[aidx];
      end else begin
         case (adr)
            `SIR_OFS_IVR:  rd_mux = norm_req ? vec_q[best_id] : spur_q;
            `SIR_OFS_CUR:  rd_mux = 32'(cur_id);
            `SIR_OFS_EN:   rd_mux = en_q;
            `SIR_OFS_PEND: rd_mux = pend;
            `SIR_OFS_FFORCE: rd_mux = ff_q;
            `SIR_OFS_DBG:  rd_mux = 32'(protect_q);
            `SIR_OFS_CLK:  rd_mux = clk_q;
            `SIR_OFS_STS:  rd_mux = sts_q;
            `SIR_OFS_MSK:  rd_mux = msk_q;
            `SIR_OFS_PROBE: rd_mux = probe_q;
            `SIR_OFS_DEC:  rd_mux = probe_dec;
            `SIR_OFS_RAW:  rd_mux = src_raw;
            `SIR_OFS_SPUR: rd_mux = spur_q;
            default:       rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Bus handshake and registered outputs.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wait_q     <= 1'b1;
         rdata_q    <= 32'h0000_0000;
         ivr_ok_q   <= 1'b0;
         ivr_id_q   <= 5'h00;
         ivr_pr_q   <= 3'h0;
         norm_n_q   <= 1'b1;
         fast_n_q   <= 1'b1;
         norm_req_q <= 1'b0;
         fast_req_q <= 1'b0;
         irq_q      <= 1'b0;
      end else begin
         wait_q     <= ~cap;
         norm_n_q   <= ~norm_req;
         fast_n_q   <= ~fast_req;
         norm_req_q <= norm_req;
         fast_req_q <= fast_req;
         irq_q      <= |(sts_q & msk_q);
         if (cap) begin
            rdata_q  <= i_avs_read ? rd_mux : 32'h0000_0000;
            ivr_ok_q <= norm_req;
            ivr_id_q <= best_id;
            ivr_pr_q <= best_pr;
         end
      end
   end

   assign o_avs_readdata           = rdata_q;
   assign o_avs_waitrequest        = wait_q;
   assign o_core_normal_irq_line_n = norm_n_q;
   assign o_core_fast_irq_line_n   = fast_n_q;
   assign o_periph_clk_en          = clk_q;
   assign o_irq                    = irq_q;

   //////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_capture;
      cap && i_avs_read && adr == `SIR_OFS_IVR;
   endsequence

   sys_window_a: assert property ((probe_q >= 32'hffffe800) |-> probe_dec[0])
      else $error("System window decode missed.");
   user_slot_a: assert property ((probe_q == 32'hfffa8000) |->
                                 probe_dec[7:0] == 8'h22)
      else $error("User slot decode wrong.");
   fast_src0_a: assert property ((pend[0] && en_q[0]) |=> !o_core_fast_irq_line_n)
      else $error("Fast pin did not reach fast line.");
   sys_or_a: assert property (src_raw[1] == (|i_system_block_irq))
      else $error("System source is not the OR of units.");
   reserved_a: assert property (((cand_norm | cand_fast) & RES_MASK) == 32'h0)
      else $error("Reserved source is active.");
   ext_map_a: assert property (src_raw[31:29] == i_ext_request_pins)
      else $error("External pins misrouted.");
   clk_lock_a: assert property ((clk_q & LOCK_MASK) == LOCK_VAL)
      else $error("Locked clock bit changed.");
   sysclk_on_a: assert property (o_periph_clk_en[1])
      else $error("System clock enable dropped.");
   prio_pre_a: assert property ((entry && sp_q != 4'h0) |-> ivr_pr_q > top_pr)
      else $error("Nested entry without higher priority.");
   mask_a: assert property ((cand_norm == 32'h0) |=> o_core_normal_irq_line_n)
      else $error("Masked sources raised the normal line.");
   ivr_vec_a: assert property ((s_capture ##0 norm_req) |=>
                               o_avs_readdata == $past(vec_q[best_id]))
      else $error("Vector read returned the wrong vector.");
   ff_redirect_a: assert property (((pend & en_q & ff_q & ~RES_MASK) != 32'h0) |=>
                                   !o_core_fast_irq_line_n)
      else $error("Forced source not on fast line.");
   protect_rd_a: assert property ((acc_rd && protect_q) |=> $stable(sp_q))
      else $error("Read in protect mode changed service state.");
   sys_level_a: assert property (
      ((|i_system_block_irq) && mode_q[1][6:5] == 2'b01) [*3] |-> pend[1])
      else $error("System level dropped while a unit holds it.");
   bus_answer_a: assert property ((req && wait_q) |=> !o_avs_waitrequest)
      else $error("Bus answer late.");
endmodule : sir_top

// ==== testbench.sv ====
/*
 Self-checking bench for the system interrupt router.
 Assumes the register offsets and masks of sir_params.svh.
*/
`timescale 1ns/1ps
`include "sir_params.svh"
module testbench
   import sir_pkg::*;
;
   logic        i_clk, i_sys_rst, i_avs_read, i_avs_write, i_fast_request_pin;
   logic [8:0]  i_avs_address;
   sir_word_t   i_avs_writedata, o_avs_readdata, o_periph_clk_en;
   logic        o_avs_waitrequest, o_core_normal_irq_line_n, o_core_fast_irq_line_n;
   logic        o_irq, normal_req, fast_req;
   logic [6:0]  i_system_block_irq;
   logic [26:0] i_periph_irq;
   logic [2:0]  i_ext_request_pins;
   int          mismatches, n_tests;

   sir_top #(.STACK_DEPTH(8)) i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_fast_request_pin(i_fast_request_pin), .i_system_block_irq(i_system_block_irq),
      .i_periph_irq(i_periph_irq), .i_ext_request_pins(i_ext_request_pins),
      .o_core_normal_irq_line_n(o_core_normal_irq_line_n),
      .o_core_fast_irq_line_n(o_core_fast_irq_line_n),
      .o_periph_clk_en(o_periph_clk_en), .o_irq(o_irq));

   sir_core_model i_core (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_normal_n(o_core_normal_irq_line_n), .i_fast_n(o_core_fast_irq_line_n),
      .o_normal_req(normal_req), .o_fast_req(fast_req));

   ////////////////////////////////////////////////////////////
   // Clock at 50 MHz.
   always #10 i_clk = !i_clk;

   task automatic chk(input sir_word_t got, input sir_word_t exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One Avalon access; the request is held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [8:0] a, input sir_word_t d,
                      output sir_word_t q);
      int n;
      @(posedge i_clk);
      i_avs_address   <= a;
      i_avs_writedata <= d;
      i_avs_write     <= w;
      i_avs_read      <= !w;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clk);
         if (o_avs_waitrequest === 1'b0) break;
      end
      q = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read  <= 1'b0;
      if (n == 50) mismatches++;
   endtask : bus

   task automatic wr(input logic [8:0] a, input sir_word_t d);
      sir_word_t q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [8:0] a, input sir_word_t e, input sir_word_t m = '1);
      sir_word_t q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rd

   // Bounded wait for a core request or the own interrupt to reach a level.
   task automatic wait_for(input int sel, input logic e);
      int n;
      logic v;
      for (n = 0; n < 12; n++) begin
         @(posedge i_clk);
         v = (sel == 0) ? normal_req : (sel == 1) ? fast_req : o_irq;
         if (v === e) break;
      end
      chk({31'h0, v}, {31'h0, e});
   endtask : wait_for

   ////////////////////////////////////////////////////////////
   task automatic t_clocks;
      chk(o_periph_clk_en, 32'h00000002);
      wr(`SIR_OFS_CLK_SET, 32'hffffffff);
      rd(`SIR_OFS_CLK, 32'h1feffffe);
      chk(o_periph_clk_en, 32'h1feffffe);
      wr(`SIR_OFS_CLK_CLR, 32'hffffffff);
      rd(`SIR_OFS_CLK, 32'h00000002);
      $display("test clocks done");
   endtask : t_clocks

   // Slot index is only meaningful inside the user window.
   task automatic t_decode;
      sir_word_t pa[7] = '{32'hffffe800, 32'hffffffff, 32'hffffe7fc, 32'hfffa4000,
                           32'hfffa8000, 32'hfffcfffc, 32'hfffd0000};
      sir_word_t ex[7] = '{32'h1, 32'h1, 32'h0, 32'h12, 32'h22, 32'hb2, 32'h0};
      sir_word_t mk[7] = '{32'h3, 32'h3, 32'h3, 32'hf3, 32'hf3, 32'hf3, 32'h3};
      for (int i = 0; i < 7; i++) begin
         wr(`SIR_OFS_PROBE, pa[i]);
         rd(`SIR_OFS_DEC, ex[i], mk[i]);
      end
      $display("test decode done");
   endtask : t_decode

   task automatic t_sources;
      for (int i = 0; i < 7; i++) begin
         i_system_block_irq <= 7'(1 << i);
         rd(`SIR_OFS_RAW, 32'h2);
      end
      i_system_block_irq <= 7'h41;
      repeat (2) @(posedge i_clk);
      i_system_block_irq <= 7'h40;
      rd(`SIR_OFS_RAW, 32'h2);
      i_system_block_irq <= 7'h00;
      rd(`SIR_OFS_RAW, 32'h0);
      for (int k = 0; k < 27; k++) begin
         i_periph_irq <= 27'(1 << k);
         rd(`SIR_OFS_RAW, (k == 13 || k == 14) ? 32'h0 : 32'(1 << (k + 2)));
      end
      i_periph_irq <= '0;
      for (int j = 0; j < 3; j++) begin
         i_ext_request_pins <= 3'(1 << j);
         rd(`SIR_OFS_RAW, 32'(1 << (29 + j)));
      end
      i_ext_request_pins <= '0;
      i_fast_request_pin <= 1'b1;
      rd(`SIR_OFS_RAW, 32'h1);
      i_fast_request_pin <= 1'b0;
      $display("test sources done");
   endtask : t_sources

   // Source 5 at priority 2 is entered, then source 9 at priority 5 preempts it.
   task automatic t_priority;
      wr(9'h014, 32'h22);
      wr(9'h024, 32'h25);
      wr(9'h094, 32'h500);
      wr(9'h0a4, 32'h900);
      wr(`SIR_OFS_EN_SET, 32'h220);
      i_periph_irq[3] <= 1'b1;
      wait_for(0, 1'b1);
      wr(`SIR_OFS_DBG, 32'h1);
      rd(`SIR_OFS_IVR, 32'h500);
      rd(`SIR_OFS_CUR, 32'h0);
      wr(`SIR_OFS_DBG, 32'h0);
      rd(`SIR_OFS_IVR, 32'h500);
      wait_for(0, 1'b0);
      rd(`SIR_OFS_CUR, 32'h5);
      i_periph_irq[7] <= 1'b1;
      wait_for(0, 1'b1);
      rd(`SIR_OFS_IVR, 32'h900);
      rd(`SIR_OFS_CUR, 32'h9);
      i_periph_irq <= '0;
      wr(`SIR_OFS_EOC, 32'h0);
      rd(`SIR_OFS_CUR, 32'h5);
      wr(`SIR_OFS_EOC, 32'h0);
      rd(`SIR_OFS_CUR, 32'h0);
      $display("test priority done");
   endtask : t_priority

   // Source 22 as level-low pends at once with its input low.
   task automatic t_mask;
      wr(9'h058, 32'h01);
      wr(`SIR_OFS_EN_SET, 32'h00400000);
      wait_for(0, 1'b1);
      wr(`SIR_OFS_EN_CLR, 32'h00400000);
      wait_for(0, 1'b0);
      wr(9'h058, 32'h20);
      $display("test mask done");
   endtask : t_mask

   task automatic t_fast;
      wr(`SIR_OFS_FFORCE, 32'h40000000);
      wr(`SIR_OFS_EN_SET, 32'h40000001);
      i_ext_request_pins[1] <= 1'b1;
      wait_for(1, 1'b1);
      chk({31'h0, normal_req}, 32'h0);
      rd(`SIR_OFS_STS, 32'h2, 32'h2);
      wr(`SIR_OFS_MSK, 32'h2);
      wait_for(2, 1'b1);
      i_ext_request_pins <= '0;
      wait_for(1, 1'b0);
      wr(`SIR_OFS_STS, 32'h2);
      wait_for(2, 1'b0);
      i_fast_request_pin <= 1'b1;
      wait_for(1, 1'b1);
      i_fast_request_pin <= 1'b0;
      wait_for(1, 1'b0);
      wr(`SIR_OFS_SPUR, 32'h5a5);
      rd(`SIR_OFS_IVR, 32'h5a5);
      rd(`SIR_OFS_STS, 32'h8, 32'h8);
      wr(`SIR_OFS_STS, 32'hf);
      rd(`SIR_OFS_STS, 32'h0, 32'hf);
      $display("test fast done");
   endtask : t_fast

   // Source 6 as rising, then falling edge; the entry clears its pending bit.
   task automatic t_edge;
      wr(9'h018, 32'h60);
      i_periph_irq[4] <= 1'b1;
      @(posedge i_clk);
      i_periph_irq[4] <= 1'b0;
      rd(`SIR_OFS_PEND, 32'h40, 32'h40);
      wr(`SIR_OFS_PEND_CLR, 32'h40);
      rd(`SIR_OFS_PEND, 32'h0, 32'h40);
      wr(9'h018, 32'h40);
      i_periph_irq[4] <= 1'b1;
      rd(`SIR_OFS_PEND, 32'h0, 32'h40);
      i_periph_irq[4] <= 1'b0;
      rd(`SIR_OFS_PEND, 32'h40, 32'h40);
      wr(9'h098, 32'h600);
      wr(`SIR_OFS_EN_SET, 32'h40);
      wait_for(0, 1'b1);
      rd(`SIR_OFS_IVR, 32'h600);
      rd(`SIR_OFS_PEND, 32'h0, 32'h40);
      wait_for(0, 1'b0);
      wr(`SIR_OFS_EOC, 32'h0);
      wr(`SIR_OFS_EN_CLR, 32'h40);
      wr(9'h018, 32'h20);
      $display("test edge done");
   endtask : t_edge

   ////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      final_report();
   end

   initial begin
      i_clk = 1'b0;
      i_sys_rst = 1'b1;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = '0;
      i_avs_writedata = '0;
      i_fast_request_pin = 1'b0;
      i_system_block_irq = '0;
      i_periph_irq = '0;
      i_ext_request_pins = '0;
      mismatches = 0;
      n_tests = 0;
      repeat (16) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_clocks();
      t_decode();
      t_sources();
      t_priority();
      t_mask();
      t_fast();
      t_edge();
      final_report();
   end
endmodule : testbench
